// file: common/lsw_pkg.sv
// Constants shared by the LCD controller status word block
package lsw_pkg;
  localparam int CLK_MHZ = 25;

  // Register byte offsets
  localparam logic [7:0] ENTRY_MODE_OFS = 8'h00;
  localparam logic [7:0] DISP_CTRL_OFS  = 8'h04;
  localparam logic [7:0] ADDR_SET_OFS   = 8'h08;
  localparam logic [7:0] START_LINE_OFS = 8'h0C;
  localparam logic [7:0] DATA_WR_OFS    = 8'h10;
  localparam logic [7:0] STATUS_OFS     = 8'h14;
  localparam logic [7:0] ADDR_CNT_OFS   = 8'h18;
  localparam logic [7:0] LINE_STATE_OFS = 8'h1C;

  // Entry mode fields
  localparam int EM_INC_POS   = 0;
  localparam int EM_SHIFT_POS = 1;
  localparam int EM_GRAM_POS  = 2;
  // Display control fields
  localparam int DC_ULBLINK_POS = 0;
  localparam int DC_UL_POS      = 1;
  localparam int DC_BLINK_POS = 2;
  localparam int DC_CUR_POS   = 3;
  localparam int DC_DISP_POS  = 4;
  // Address set fields, widths and line state pending bit
  localparam int AS_TARGET_POS = 8;
  localparam int ADDR_W        = 8;
  localparam int LINE_W        = 6;
  localparam int LINE_PEND_POS = 8;

  // Status byte layout
  localparam int ST_BUSY1_POS  = 7;
  localparam int ST_BUSY2_POS  = 6;
  localparam int ST_TARGET_POS = 5;
  localparam int ST_INC_POS    = 4;
  localparam int ST_SHIFT_POS  = 3;
  localparam int ST_GRAM_POS   = 2;
  localparam int ST_DISP_POS   = 1;
  localparam int ST_UL_POS     = 0;

  // Reset values
  localparam logic [2:0] ENTRY_MODE_RST = 3'h1;
  localparam logic [4:0] DISP_CTRL_RST  = 5'h00;
  localparam logic [8:0] ADDR_RST       = 9'h000;
  localparam logic [5:0] LINE_RST       = 6'h00;

  // Busy times and derived cycle counts (least times, rounded up)
  localparam int CMD_BUSY_NS    = 2000;
  localparam int LINE_BUSY_NS   = 20000;
  localparam int TIMER_W        = 10;
  localparam int CMD_BUSY_CYC   = (CMD_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int LINE_BUSY_CYC  = (LINE_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam logic [TIMER_W-1:0] CMD_BUSY_LOAD  = TIMER_W'(CMD_BUSY_CYC);
  localparam logic [TIMER_W-1:0] LINE_BUSY_LOAD = TIMER_W'(LINE_BUSY_CYC);
endpackage

// file: design/lsw_busy_timer.sv
// Loadable busy down-counter with end-of-busy pulse
`timescale 1ns/100ps
module lsw_busy_timer
  import lsw_pkg::*;
#(
  parameter int WIDTH = TIMER_W
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] loadValue,
  output logic                  busy,
  output logic                  done
);
  logic [WIDTH-1:0] count_reg;
  logic             loadWins;

  // A shorter new load never cuts short a longer busy already running
  assign loadWins = start && (loadValue > count_reg);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (loadWins) begin
      count_reg <= loadValue;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= loadWins || (count_reg > WIDTH'(1));
      done <= !loadWins && (count_reg == WIDTH'(1));
    end
  end
endmodule

// file: design/lsw_status_word.sv
// LCD controller command registers, busy flags and status word over APB
`timescale 1ns/100ps

module lsw_status_word
  import lsw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busyPrimaryFlag,
  output logic             busySecondaryFlag,
  output logic      [7:0]  statusByte,
  output logic             displayOn,
  output logic      [5:0]  startLine
);
  // Configuration state
  logic [2:0]        entryMode_reg;
  logic [4:0]        dispCtrl_reg;
  logic              ramTargetSelectBit_reg;
  logic [ADDR_W-1:0] addrCount_reg;
  logic [LINE_W-1:0] pendingLine_reg;
  logic              linePending_reg;
  logic [LINE_W-1:0] activeLine_reg;

  // Bus handshake state and pin copies
  logic              accept_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [31:0]       prdata_reg;
  logic [7:0]        statusByte_reg;
  logic              displayOn_reg;
  logic [LINE_W-1:0] startLine_reg;

  // Timer outputs
  logic              primaryBusy;
  logic              secondaryBusy;
  logic              secondaryDone;

  // Decode
  logic              accessFirst;
  logic              accessDone;
  logic              isCmdAddr;
  logic              isRoAddr;
  logic              isMapped;
  logic              acceptNext;
  logic              errNext;
  logic              cmdCommit;
  logic              lineCommit;
  logic              addrCommit;
  logic              dataCommit;
  logic              entryCommit;
  logic              dispCommit;
  logic [7:0]        statusNow;
  logic [31:0]       readValue;
  logic              underlineActive;

  assign accessFirst = psel && penable && !pready_reg;
  assign accessDone  = psel && penable && pready_reg;

  always_comb begin
    isCmdAddr = 1'b0;
    isRoAddr  = 1'b0;
    unique case (paddr)
      ENTRY_MODE_OFS, DISP_CTRL_OFS, ADDR_SET_OFS,
      START_LINE_OFS, DATA_WR_OFS: isCmdAddr = 1'b1;
      STATUS_OFS, ADDR_CNT_OFS, LINE_STATE_OFS: isRoAddr = 1'b1;
      default: begin
        isCmdAddr = 1'b0;
        isRoAddr  = 1'b0;
      end
    endcase
  end

  assign isMapped = isCmdAddr || isRoAddr;

  // Writes decided at the first access cycle so a busy ending later cannot flip it
  assign acceptNext = pwrite && isCmdAddr && !primaryBusy;
  assign errNext    = !isMapped || (pwrite && !acceptNext);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      accept_reg  <= 1'b0;
    end else begin
      pready_reg  <= accessFirst;
      pslverr_reg <= accessFirst && errNext;
      accept_reg  <= accessFirst && acceptNext;
    end
  end

  assign cmdCommit   = accessDone && accept_reg;
  assign entryCommit = cmdCommit && (paddr == ENTRY_MODE_OFS);
  assign dispCommit  = cmdCommit && (paddr == DISP_CTRL_OFS);
  assign addrCommit  = cmdCommit && (paddr == ADDR_SET_OFS);
  assign lineCommit  = cmdCommit && (paddr == START_LINE_OFS);
  assign dataCommit  = cmdCommit && (paddr == DATA_WR_OFS);

  // Every accepted command makes the controller busy
  lsw_busy_timer #(
    .WIDTH     (TIMER_W)
  ) u_primary (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (cmdCommit),
    .loadValue (CMD_BUSY_LOAD),
    .busy      (primaryBusy),
    .done      ()
  );

  // Secondary busy covers all commands plus the longer start-line revision
  lsw_busy_timer #(
    .WIDTH     (TIMER_W)
  ) u_secondary (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (cmdCommit),
    .loadValue (lineCommit ? LINE_BUSY_LOAD : CMD_BUSY_LOAD),
    .busy      (secondaryBusy),
    .done      (secondaryDone)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      entryMode_reg <= ENTRY_MODE_RST;
    end else if (entryCommit) begin
      entryMode_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dispCtrl_reg <= DISP_CTRL_RST;
    end else if (dispCommit) begin
      dispCtrl_reg <= pwdata[4:0];
    end
  end

  // Address counter: loaded by address set, stepped by each data write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {ramTargetSelectBit_reg, addrCount_reg} <= ADDR_RST;
    end else if (addrCommit) begin
      ramTargetSelectBit_reg <= pwdata[AS_TARGET_POS];
      addrCount_reg          <= pwdata[ADDR_W-1:0];
    end else if (dataCommit) begin
      if (entryMode_reg[EM_INC_POS]) begin
        addrCount_reg <= addrCount_reg + ADDR_W'(1);
      end else begin
        addrCount_reg <= addrCount_reg - ADDR_W'(1);
      end
    end
  end

  // A newer start line replaces the pending one and restarts its revision
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendingLine_reg <= LINE_RST;
      linePending_reg <= 1'b0;
    end else if (lineCommit) begin
      pendingLine_reg <= pwdata[LINE_W-1:0];
      linePending_reg <= 1'b1;
    end else if (secondaryDone) begin
      linePending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      activeLine_reg <= LINE_RST;
    end else if (secondaryDone && linePending_reg && !lineCommit) begin
      activeLine_reg <= pendingLine_reg;
    end
  end

  assign underlineActive = dispCtrl_reg[DC_UL_POS] || dispCtrl_reg[DC_ULBLINK_POS];

  // Low six bits held at zero while busy; their value has no meaning then
  always_comb begin
    statusNow                = 8'h00;
    statusNow[ST_BUSY1_POS]  = primaryBusy;
    statusNow[ST_BUSY2_POS]  = secondaryBusy;
    if (!primaryBusy) begin
      statusNow[ST_TARGET_POS] = ramTargetSelectBit_reg;
      statusNow[ST_INC_POS]    = entryMode_reg[EM_INC_POS];
      statusNow[ST_SHIFT_POS]  = entryMode_reg[EM_SHIFT_POS];
      statusNow[ST_GRAM_POS]   = entryMode_reg[EM_GRAM_POS];
      statusNow[ST_DISP_POS]   = dispCtrl_reg[DC_DISP_POS];
      statusNow[ST_UL_POS]     = underlineActive;
    end
  end

  always_comb begin
    readValue = 32'h0000_0000;
    unique case (paddr)
      ENTRY_MODE_OFS: readValue[2:0] = entryMode_reg;
      DISP_CTRL_OFS:  readValue[4:0] = dispCtrl_reg;
      ADDR_SET_OFS,
      ADDR_CNT_OFS:   readValue[8:0] = {ramTargetSelectBit_reg, addrCount_reg};
      START_LINE_OFS: readValue[LINE_W-1:0] = pendingLine_reg;
      STATUS_OFS:     readValue[7:0] = statusNow;
      LINE_STATE_OFS: begin
        readValue[LINE_W-1:0]    = activeLine_reg;
        readValue[LINE_PEND_POS] = linePending_reg;
      end
      default:        readValue = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (accessFirst && !pwrite) begin
      prdata_reg <= readValue;
    end else if (!psel) begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  // Pin copies, one cycle behind internal state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusByte_reg <= 8'h00;
      displayOn_reg  <= 1'b0;
      startLine_reg  <= LINE_RST;
    end else begin
      statusByte_reg <= statusNow;
      displayOn_reg  <= dispCtrl_reg[DC_DISP_POS];
      startLine_reg  <= activeLine_reg;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign busyPrimaryFlag   = primaryBusy;
  assign busySecondaryFlag = secondaryBusy;
  assign statusByte        = statusByte_reg;
  assign displayOn         = displayOn_reg;
  assign startLine         = startLine_reg;
endmodule

// file: bench/lsw_sva.sv
// Port-level checks of the status word block
`timescale 1ns/100ps
module lsw_sva
  import lsw_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busyPrimaryFlag,
  input wire logic        busySecondaryFlag,
  input wire logic [7:0]  statusByte,
  input wire logic        displayOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic req;
  logic cmdAddr;
  assign req = psel && penable && !pready && pwrite;
  assign cmdAddr = paddr <= DATA_WR_OFS && paddr[1:0] == 2'h0;
  sequence busyHold;
    busyPrimaryFlag [*8] ##42 busyPrimaryFlag;
  endsequence
  sequence okThenBusy;
    pready && !pslverr ##1 busyPrimaryFlag;
  endsequence
  busy_copy_a: assert property (statusByte[7] == $past(busyPrimaryFlag))
    else $error("busy1 copy wrong");
  busy2_copy_a: assert property (statusByte[6] == $past(busySecondaryFlag))
    else $error("busy2 copy wrong");
  disp_echo_a: assert property (!$past(busyPrimaryFlag) |-> statusByte[1] == displayOn)
    else $error("display bit wrong");
  busy_super_a: assert property (busyPrimaryFlag |-> busySecondaryFlag)
    else $error("busy2 not set");
  refuse_busy_a: assert property (req && cmdAddr && busyPrimaryFlag |=> pready && pslverr)
    else $error("busy write taken");
  accept_cmd_a: assert property (req && cmdAddr && !busyPrimaryFlag |=> okThenBusy)
    else $error("idle write refused");
  busy_time_a: assert property ($rose(busyPrimaryFlag) |-> busyHold ##1 !busyPrimaryFlag)
    else $error("busy length wrong");
  status_read_a: assert property (pready && !pwrite && !pslverr && paddr == STATUS_OFS
    |-> prdata == {24'h0, statusByte})
    else $error("status read wrong");
endmodule

bind lsw_status_word lsw_sva sva_u (.*);

// file: bench/lsw_host_model.sv
// Bus master model of the host processor
`timescale 1ns/100ps
module lsw_host_model
  import lsw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  initial begin
    {psel, penable, pwrite} <= 3'h0;
    paddr <= 8'hFF;
    pwdata <= 32'h0;
  end
  // Entered just after a rising edge; one idle cycle follows
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    // Stale address and data must not pass for live ones
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask
  task automatic poll();
    logic [31:0] r;
    logic        err;
    do xfer(1'b0, STATUS_OFS, 32'h0, r, err); while (r[ST_BUSY1_POS] !== 1'b0);
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench of the status word block
`timescale 1ns/100ps
module testbench
  import lsw_pkg::*;
;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic        busyPrimaryFlag, busySecondaryFlag, displayOn;
  logic [7:0]  paddr, statusByte;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  startLine;
  logic [2:0]  em;
  logic [4:0]  dc;
  logic [8:0]  ad;
  int          n_mismatch, check_count, cyc;

  lsw_status_word dut_u (.*);
  lsw_host_model host_u (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] expSt(logic [2:0] m, logic [4:0] c, logic t);
    return {26'h0, t, m[0], m[1], m[2], c[4], c[1] | c[0]};
  endfunction

  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic rdr(logic [7:0] a);
    host_u.xfer(1'b0, a, 32'h0, rd, e);
  endtask

  task automatic cmd(logic [7:0] a, logic [31:0] d);
    host_u.xfer(1'b1, a, d, rd, e);
    chk("write error", 32'h0, {31'h0, e});
    host_u.poll();
  endtask

  // Hang guard; the run needs some 6300 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    sys_rst = 1'b1;
    {n_mismatch, check_count, cyc} = '0;
    void'($urandom(32'h18F3));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdr(STATUS_OFS);
    chk("reset status", 32'h10, rd);
    repeat (24) begin
      em = 3'($urandom());
      dc = 5'($urandom());
      ad = 9'($urandom());
      cmd(ENTRY_MODE_OFS, {29'h0, em});
      cmd(DISP_CTRL_OFS, {27'h0, dc});
      cmd(ADDR_SET_OFS, {23'h0, ad});
      rdr(STATUS_OFS);
      chk("status", expSt(em, dc, ad[8]), rd);
      rdr(ENTRY_MODE_OFS);
      chk("entry mode", {29'h0, em}, rd);
      cmd(DATA_WR_OFS, 32'h0);
      rdr(ADDR_CNT_OFS);
      chk("step", {23'h0, ad[8], em[0] ? ad[7:0] + 8'h01 : ad[7:0] - 8'h01}, rd);
    end
    host_u.xfer(1'b1, DISP_CTRL_OFS, 32'h10, rd, e);
    rdr(STATUS_OFS);
    chk("busy seen", 32'h1, {31'h0, rd[7]});
    host_u.xfer(1'b1, DISP_CTRL_OFS, 32'h0, rd, e);
    chk("refused", 32'h1, {31'h0, e});
    host_u.poll();
    rdr(STATUS_OFS);
    chk("display kept", expSt(em, 5'h10, ad[8]), rd);
    cmd(START_LINE_OFS, 32'h15);
    rdr(STATUS_OFS);
    chk("busy2 only", 32'h40, rd & 32'hC0);
    cmd(START_LINE_OFS, 32'h2A);
    do rdr(STATUS_OFS); while (rd[6] !== 1'b0);
    repeat (2) @(posedge clk);
    chk("start line", 32'h2A, {26'h0, startLine});
    rdr(LINE_STATE_OFS);
    chk("line state", 32'h2A, rd);
    host_u.xfer(1'b1, STATUS_OFS, 32'hFF, rd, e);
    chk("status write", 32'h1, {31'h0, e});
    rdr(8'h20);
    chk("unmapped", 32'h1, {31'h0, e});
    summarize();
  end
endmodule
